// >>> bench/lrq_initiator.sv
// Purpose: initiator-side model that builds query command blocks and moves them over apb
// Assumes: the slave samples requests on the rising clock edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module lrq_initiator
   import lrq_pkg::*;
(
   // clock
   input wire logic clock_in,
   // apb master side
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out,
   input wire logic [31:0] prdata_in,
   input wire logic pready_in,
   input wire logic pslverr_in
);
   // ----------------------------------------------------------------
   // bus idle at time zero
   // ----------------------------------------------------------------
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'hff;
      pwdata_out = 32'h0;
   end
   // ----------------------------------------------------------------
   // one transfer: setup, access held until pready, then release
   // ----------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
      output logic [31:0] rdv, output logic err);
      // leave an edge first so no line is assigned twice in one step
      @(posedge clock_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= addr;
      pwdata_out <= data;
      @(posedge clock_in);
      penable_out <= 1'b1;
      @(posedge clock_in);
      // wait as long as the slave needs; the bench watchdog judges a hang
      while (pready_in !== 1'b1) begin
         @(posedge clock_in);
      end
      rdv = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // stale values must not look like a live request
      paddr_out <= ~addr;
      pwdata_out <= ~data;
   endtask
   // ----------------------------------------------------------------
   // query command block, multi-byte fields most significant first
   // ----------------------------------------------------------------
   task automatic query(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
      input logic [7:0] rop, input logic [15:0] rsa, input logic [31:0] alc);
      logic [31:0] rdv;
      logic err;
      xfer(1'b1, OFS_CDB0, {rop, b2, b1, b0}, rdv, err);
      xfer(1'b1, OFS_CDB1, {alc[23:16], alc[31:24], rsa[7:0], rsa[15:8]}, rdv, err);
      // control byte keeps vendor and allegiance bits clear
      xfer(1'b1, OFS_CDB2, {8'h00, 8'h00, alc[7:0], alc[15:8]}, rdv, err);
   endtask
endmodule

// >>> bench/lun_report_and_opcode_query_test.sv
// Purpose: self-checking bench for the unit-report and opcode-query block
// Assumes: zero-wait apb slave, result two edges after the start write
// Notes: small command count keeps short allocation lengths reachable
`timescale 1ns/1ps
module lun_report_and_opcode_query_test;
   import lrq_pkg::*;
   // ----------------------------------------------------------------
   // signals and tables
   // ----------------------------------------------------------------
   localparam logic [31:0] N_CMDS = 32'h5; // short all-commands list
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int error_cnt = 0;
   int n_tests = 0;
   logic [7:0] sel_tab [4] = '{8'h11, 8'h12, 8'h00, 8'h10}; // select codes
   logic [7:0] op_tab [4] = '{8'ha3, 8'h9e, 8'h12, 8'h28}; // requested opcodes
   always #2 clock_in = ~clock_in; // 250 MHz
   // ----------------------------------------------------------------
   // design and initiator
   // ----------------------------------------------------------------
   lrq_top #(.SA_OPCODES((256'h1 << 8'ha3) | (256'h1 << 8'h9e)), .NUM_CMDS(N_CMDS)) uut (
      .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr));
   lrq_initiator ini (
      .clock_in(clock_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(pslverr));
   // ----------------------------------------------------------------
   // compare, report and close
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // watchdog: the whole run needs about 1200 cycles
   initial begin
      repeat (40000) @(posedge clock_in);
      error_cnt++;
      complete_run();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int i, j, exp, len, ret, seed;
      logic [31:0] d, alc;
      logic e, flag, q, sa, bad;
      logic [2:0] opt;
      logic [7:0] op0, b1, b2, rop;
      logic [15:0] rsa;
      seed = $urandom(9);
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      // unmapped and misaligned places are refused
      ini.xfer(1'b0, 8'h30, 32'h0, d, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, d);
      ini.xfer(1'b1, 8'h06, 32'h5a5a_a5a5, d, e);
      chk("misaligned error", 32'h1, 32'(e));
      // unit list for the four tabled select codes and every unit kind
      for (i = 0; i < 16; i++) begin
         ini.xfer(1'b1, OFS_CTRL, {14'h0, i[3], i[2], sel_tab[i % 4], 8'h00}, d, e);
         exp = (sel_tab[i % 4] == 8'h11) ? (i[2] ? 8 : 0) : (sel_tab[i % 4] == 8'h12) ? (i[3] ? 8 : 0) : 8;
         ini.xfer(1'b0, OFS_LIST0, 32'h0, d, e);
         chk("list length", {8'(exp), 24'h0}, d);
         for (j = 1; j < 4; j++) begin
            ini.xfer(1'b0, OFS_LIST0 + 8'(4 * j), 32'h0, d, e);
            chk("list body", 32'h0, d);
         end
      end
      // query decode across all options, flag values and bad blocks
      for (i = 0; i < 32; i++) begin
         opt = 3'(i);
         flag = i[3];
         op0 = (i % 7 == 6) ? 8'($urandom_range(0, 255)) : QUERY_OPCODE;
         b1 = {(i % 11 == 5) ? 3'h2 : 3'h0, (i % 13 == 9) ? 5'h0d : QUERY_SA};
         b2 = {flag, (i % 9 == 4) ? 4'h4 : 4'h0, opt};
         rop = op_tab[$urandom_range(0, 3)];
         rsa = 16'($urandom);
         // options 011b get a roomy allocation so the full length shows
         alc = (opt == 3'h3) ? 32'h0000_0200 : 32'($urandom_range(0, 120));
         ini.query(op0, b1, b2, rop, rsa, alc);
         ini.xfer(1'b0, OFS_CDB1, 32'h0, d, e);
         chk("cdb readback", {alc[23:16], alc[31:24], rsa[7:0], rsa[15:8]}, d);
         ini.xfer(1'b1, OFS_CTRL, 32'h1, d, e);
         repeat (3) @(posedge clock_in);
         d = 32'h0;
         // poll until done; the watchdog catches a result that never comes
         while (d[ST_DONE] !== 1'b1) begin
            ini.xfer(1'b0, OFS_STAT, 32'h0, d, e);
         end
         // reference model of the decode
         q = (op0 == QUERY_OPCODE) && (b1[4:0] == QUERY_SA);
         sa = (rop == 8'ha3) || (rop == 8'h9e);
         bad = !q || (b1[7:5] != 3'h0) || (b2[6:3] != 4'h0);
         bad = bad || (opt == 3'h1 && sa) || (opt == 3'h2 && !sa) || opt > 3'h3;
         len = (opt == 3'h0) ? 4 + N_CMDS * (flag ? 20 : 8) : 16 + (flag ? 12 : 0);
         ret = bad ? 0 : (alc < len ? alc : len);
         chk("busy after done", 32'h0, 32'(d[ST_BUSY]));
         chk("query seen", 32'(q), 32'(d[ST_QUERY]));
         chk("timeout flag", 32'(flag), 32'(d[ST_TD_FLAG]));
         chk("options", 32'(opt), 32'(d[ST_OPT_LO +: 3]));
         chk("check condition", 32'(bad), 32'(d[ST_CHECK]));
         if (!bad) chk("all form", 32'(opt == 3'h0), 32'(d[ST_ALL]));
         ini.xfer(1'b0, OFS_RETLEN, 32'h0, d, e);
         chk("return length", 32'(ret), d);
         ini.xfer(1'b0, OFS_REQ, 32'h0, d, e);
         chk("requested fields", {8'h00, rsa, rop}, d);
         ini.xfer(1'b0, OFS_ALLOC, 32'h0, d, e);
         chk("allocation", alc, d);
      end
      complete_run();
   end
endmodule

// >>> src/lrq_cdb_decode.sv
// Purpose: splits a query command block into its fields
// Assumes: load is a one-cycle pulse from the same clock
// Notes: fields register on load, so they hold while software rewrites the cdb
`timescale 1ns/1ps
module lrq_cdb_decode (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // command block and decoded fields
   lrq_cdb_if.dec bus
);
   import lrq_pkg::*;

   typedef struct packed {
      logic done;
      logic is_query;
      logic rsvd_ok;
      logic timeout_descriptor_request_flag;
      logic [2:0] options;
      logic [7:0] req_op;
      logic [15:0] req_sa;
      logic [31:0] alloc;
   } lrq_dec_s;

   lrq_dec_s st_reg; // decoded fields
   lrq_dec_s st_next;

   function automatic logic [7:0] cbyte(input logic [95:0] c, input int n);
      cbyte = c[8*n +: 8];
   endfunction

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.done = bus.load;
      if (bus.load) begin
         // byte 1 sits at bits 15:8 and byte 2 at bits 23:16
         st_next.is_query = (cbyte(bus.cdb, 0) == QUERY_OPCODE)
            && (bus.cdb[12:8] == QUERY_SA);
         // upper byte-1 bits and byte-2 bits 6:3 must be zero
         st_next.rsvd_ok = (bus.cdb[15:13] == 3'h0)
            && (bus.cdb[22:19] == 4'h0);
         st_next.timeout_descriptor_request_flag = bus.cdb[16 + TD_FLAG_BIT];
         st_next.options = bus.cdb[18:16];
         // multi-byte fields arrive most significant byte first
         st_next.req_op = cbyte(bus.cdb, 3);
         st_next.req_sa = {cbyte(bus.cdb, 4), cbyte(bus.cdb, 5)};
         st_next.alloc = {cbyte(bus.cdb, 6), cbyte(bus.cdb, 7),
            cbyte(bus.cdb, 8), cbyte(bus.cdb, 9)};
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.done = st_reg.done;
   assign bus.is_query = st_reg.is_query;
   assign bus.rsvd_ok = st_reg.rsvd_ok;
   assign bus.timeout_descriptor_request_flag = st_reg.timeout_descriptor_request_flag;
   assign bus.options = st_reg.options;
   assign bus.req_op = st_reg.req_op;
   assign bus.req_sa = st_reg.req_sa;
   assign bus.alloc = st_reg.alloc;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_alloc_order: assert property (@(posedge clock_in) disable iff (rst_in)
      bus.load |=> bus.alloc == {$past(bus.cdb[55:48]), $past(bus.cdb[63:56]),
         $past(bus.cdb[71:64]), $past(bus.cdb[79:72])})
      else $error("allocation length byte order wrong");
   chk_query_match: assert property (@(posedge clock_in) disable iff (rst_in)
      bus.load && bus.cdb[7:0] == QUERY_OPCODE && bus.cdb[12:8] == QUERY_SA
         |=> bus.done && bus.is_query)
      else $error("query opcode not recognised");
   chk_flag_decode: assert property (@(posedge clock_in) disable iff (rst_in)
      bus.load |=> bus.timeout_descriptor_request_flag == $past(bus.cdb[23])
         && bus.options == $past(bus.cdb[18:16]))
      else $error("byte 2 fields decoded wrongly");
endmodule

// >>> src/lrq_cdb_if.sv
// Purpose: carries a command block to the decoder and its fields back
// Assumes: single clock domain
// Notes: fields are valid from the done pulse until the next load
`timescale 1ns/1ps
interface lrq_cdb_if;
   logic [95:0] cdb; // command bytes 0-11, byte n at bits 8n+7:8n
   logic load; // one-cycle pulse: decode cdb
   logic done; // one-cycle pulse: fields valid
   logic is_query; // opcode and service action match
   logic rsvd_ok; // reserved bits of bytes 1 and 2 are zero
   logic timeout_descriptor_request_flag; // byte 2 bit 7: append timeouts descriptors
   logic [2:0] options; // reporting options
   logic [7:0] req_op;
   logic [15:0] req_sa;
   logic [31:0] alloc;
   modport host (output cdb, output load, input done, input is_query, input rsvd_ok,
      input timeout_descriptor_request_flag, input options, input req_op, input req_sa, input alloc);
   modport dec (input cdb, input load, output done, output is_query, output rsvd_ok,
      output timeout_descriptor_request_flag, output options, output req_op, output req_sa, output alloc);
endinterface

// >>> src/lrq_pkg.sv
// Purpose: shared constants for the unit-report and opcode-query block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: command block bytes sit little-endian within each cdb word
package lrq_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CDB0 = 8'h00; // command bytes 0-3
   localparam logic [7:0] OFS_CDB1 = 8'h04; // command bytes 4-7
   localparam logic [7:0] OFS_CDB2 = 8'h08; // command bytes 8-11
   localparam logic [7:0] OFS_CTRL = 8'h0c; // start, select code, unit kind
   localparam logic [7:0] OFS_STAT = 8'h10; // decode result
   localparam logic [7:0] OFS_REQ = 8'h14; // requested opcode and action
   localparam logic [7:0] OFS_ALLOC = 8'h18; // allocation length
   localparam logic [7:0] OFS_RETLEN = 8'h1c; // bytes to return
   localparam logic [7:0] OFS_LIST0 = 8'h20; // unit list bytes 0-3
   localparam logic [7:0] OFS_LIST3 = 8'h2c; // unit list bytes 12-15
   // ----------------------------------------------------------------
   // control and status fields
   // ----------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_SEL_LO = 8;
   localparam int CTRL_LUN0 = 16; // handling unit is unit zero or reporting unit
   localparam int CTRL_ADMIN = 17; // handling unit is administrative
   localparam int ST_DONE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_QUERY = 2;
   localparam int ST_TD_FLAG = 3; // timeout descriptor flag
   localparam int ST_OPT_LO = 4;
   localparam int ST_CHECK = 7;
   localparam int ST_ALL = 8;
   // ----------------------------------------------------------------
   // command block codes and layout
   // ----------------------------------------------------------------
   localparam logic [7:0] QUERY_OPCODE = 8'ha3;
   localparam logic [4:0] QUERY_SA = 5'h0c;
   localparam logic [7:0] SEL_ADMIN_LVL1 = 8'h11;
   localparam logic [7:0] SEL_CONGLOM = 8'h12;
   localparam int TD_FLAG_BIT = 7; // flag position in byte 2
   localparam logic [2:0] OPT_ALL = 3'h0;
   localparam logic [2:0] OPT_OP = 3'h1;
   localparam logic [2:0] OPT_OP_SA = 3'h2;
   localparam logic [2:0] OPT_OP_SA_ANY = 3'h3;
   // ----------------------------------------------------------------
   // lengths in bytes
   // ----------------------------------------------------------------
   localparam logic [31:0] UNIT_LIST_LEN = 32'h0000_0008;
   localparam logic [31:0] LIST_HDR_LEN = 32'h0000_0008;
   localparam logic [31:0] ALL_HDR_LEN = 32'h0000_0004;
   localparam logic [31:0] DESC_LEN = 32'h0000_0008;
   localparam logic [31:0] TIMEOUT_LEN = 32'h0000_000c;
   localparam logic [31:0] ONE_LEN = 32'h0000_0010;
endpackage

// >>> src/lrq_top.sv
// Purpose: unit-report list and supported-opcode query handling over APB
// Assumes: software loads the cdb words, then writes start in the control word
// Notes: zero-wait APB slave; results appear two cycles after start
`timescale 1ns/1ps
module lrq_top #(
   parameter logic [255:0] SA_OPCODES = 256'h1 << 8'ha3, // opcodes owning service actions
   parameter logic [31:0] NUM_CMDS = 32'h20 // commands in the all-commands list
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out
);
   import lrq_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // all block state lives in one struct so reset clears it in one go
   typedef struct packed {
      logic [95:0] cdb; // loaded command block
      logic [7:0] sel_code; // select-report code
      logic lun0; // handling unit is unit zero or reporting unit
      logic admin; // handling unit is administrative
      logic busy; // decode in flight
      logic done; // results valid
      logic check; // command ends with check condition
      logic all_fmt; // all-commands form chosen
      logic [31:0] list_len; // unit list length
      logic [31:0] retlen; // bytes actually returned
      logic [31:0] rdata; // apb read data
      logic load; // start pulse toward the decoder
   } lrq_top_s;

   lrq_top_s st_reg;
   lrq_top_s st_next;
   // carries the block to the decoder and the fields back
   lrq_cdb_if cdb_bus ();

   logic setup; // first apb cycle
   logic access; // apb access cycle
   logic mapped; // address hits a register
   logic [31:0] avail; // full query parameter data length
   logic [31:0] sa_len; // per descriptor length
   logic op_has_sa; // requested opcode owns service actions
   logic [31:0] list_word0; // bytes 0-3 of the unit list
   logic td_flag; // timeout descriptors asked for

   // field splitter; its registered fields survive cdb rewrites
   lrq_cdb_decode u_dec (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .bus(cdb_bus)
   );

   // the decoder sees the stored block and the start pulse
   assign cdb_bus.cdb = st_reg.cdb;
   assign cdb_bus.load = st_reg.load;
   // short local name for the decoded byte-2 flag
   assign td_flag = cdb_bus.timeout_descriptor_request_flag;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // phase decode; the bus needs no wait states here
   assign setup = psel_in && !penable_in;
   assign access = psel_in && penable_in;
   // every aligned word up to the last list word is mapped
   assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFS_LIST3);
   // zero wait states: read data is captured in setup, so one cycle suffices
   assign pready_out = 1'b1;
   assign pslverr_out = access && !mapped;
   // read data leave a flop, so they never glitch with the address
   assign prdata_out = st_reg.rdata;

   // length field is stored most significant byte first in byte 0
   assign list_word0 = {st_reg.list_len[7:0], st_reg.list_len[15:8],
      st_reg.list_len[23:16], st_reg.list_len[31:24]};

   // ----------------------------------------------------------------
   // query lengths
   // ----------------------------------------------------------------
   // one bit per opcode, so the lookup is a single mux
   assign op_has_sa = SA_OPCODES[cdb_bus.req_op];
   // the timeouts descriptor rides on every descriptor or none
   assign sa_len = DESC_LEN + (td_flag ? TIMEOUT_LEN : 32'h0);
   // full parameter data length before truncation
   always_comb begin
      if (cdb_bus.options == OPT_ALL) begin
         // requested opcode and action play no part in this form
         avail = ALL_HDR_LEN + NUM_CMDS * sa_len;
      end else begin
         // one-command form: fixed data plus the optional descriptor
         avail = ONE_LEN + (td_flag ? TIMEOUT_LEN : 32'h0);
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // the start pulse lasts one cycle
      st_next.load = 1'b0;
      // read data captured in the setup cycle
      if (setup && !pwrite_in) begin
         unique case (paddr_in)
            OFS_CDB0: st_next.rdata = st_reg.cdb[31:0];
            OFS_CDB1: st_next.rdata = st_reg.cdb[63:32];
            OFS_CDB2: st_next.rdata = st_reg.cdb[95:64];
            OFS_CTRL: st_next.rdata = {14'h0, st_reg.admin, st_reg.lun0, st_reg.sel_code, 8'h0};
            // status mixes live decoder fields with local flags
            OFS_STAT: st_next.rdata = {23'h0, st_reg.all_fmt, st_reg.check, cdb_bus.options,
               td_flag, cdb_bus.is_query, st_reg.busy, st_reg.done};
            OFS_REQ: st_next.rdata = {8'h0, cdb_bus.req_sa, cdb_bus.req_op};
            OFS_ALLOC: st_next.rdata = cdb_bus.alloc;
            OFS_RETLEN: st_next.rdata = st_reg.retlen;
            OFS_LIST0: st_next.rdata = list_word0;
            // reserved bytes and the single unit identifier are all zero
            default: st_next.rdata = 32'h0;
         endcase
      end
      // writes take effect at the access edge
      if (access && pwrite_in) begin
         unique case (paddr_in)
            OFS_CDB0: st_next.cdb[31:0] = pwdata_in;
            OFS_CDB1: st_next.cdb[63:32] = pwdata_in;
            OFS_CDB2: st_next.cdb[95:64] = pwdata_in;
            OFS_CTRL: begin
               st_next.sel_code = pwdata_in[CTRL_SEL_LO +: 8];
               st_next.lun0 = pwdata_in[CTRL_LUN0];
               st_next.admin = pwdata_in[CTRL_ADMIN];
               // a start while busy is ignored so the decode stays whole
               if (pwdata_in[CTRL_START] && !st_reg.busy) begin
                  st_next.load = 1'b1;
                  st_next.busy = 1'b1;
                  st_next.done = 1'b0;
               end
            end
            default: begin
               // read-only and unmapped words ignore writes
            end
         endcase
      end
      // unit list: one unit only, so a non-empty list is always 8 bytes
      if (st_next.sel_code == SEL_ADMIN_LVL1) begin
         // unit zero satisfies every addressing class allowed here
         st_next.list_len = st_next.lun0 ? UNIT_LIST_LEN : 32'h0;
      end else if (st_next.sel_code == SEL_CONGLOM) begin
         // no subsidiary units exist, so the list is the handling unit alone
         st_next.list_len = st_next.admin ? UNIT_LIST_LEN : 32'h0;
      end else begin
         st_next.list_len = UNIT_LIST_LEN;
      end
      // query result
      if (cdb_bus.done) begin
         st_next.busy = 1'b0;
         st_next.done = 1'b1;
         st_next.all_fmt = cdb_bus.options == OPT_ALL;
         // the reporting options pick the form and its legality
         unique case (cdb_bus.options)
            OPT_ALL: st_next.check = 1'b0;
            OPT_OP: st_next.check = op_has_sa;
            OPT_OP_SA: st_next.check = !op_has_sa;
            OPT_OP_SA_ANY: st_next.check = 1'b0;
            default: st_next.check = 1'b1;
         endcase
         // a foreign or malformed block overrides every option
         if (!cdb_bus.is_query || !cdb_bus.rsvd_ok) begin
            st_next.check = 1'b1;
         end
         // truncate to the allocation length
         st_next.retlen = (cdb_bus.alloc < avail) ? cdb_bus.alloc : avail;
         // a refused command returns no parameter data
         if (st_next.check) begin
            st_next.retlen = 32'h0;
         end
      end
   end

   // one register stage for all state; reset clears every field
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // a start pulse, and the finished result two edges later
   sequence s_start;
      st_reg.load;
   endsequence
   sequence s_result;
      ##2 (st_reg.done && !st_reg.busy);
   endsequence

   // a start raises busy and drops the old result at once
   chk_start_busy: assert property (@(posedge clock_in) disable iff (rst_in)
      s_start |-> st_reg.busy && !st_reg.done)
      else $error("start did not mark the decode busy");

   chk_start_done: assert property (@(posedge clock_in) disable iff (rst_in)
      s_start |-> s_result)
      else $error("query result not ready two cycles after start");

   // ----------------------------------------------------------------
   // checks: unit list
   // ----------------------------------------------------------------
   chk_sel11_list: assert property (@(posedge clock_in) disable iff (rst_in)
      st_reg.sel_code == SEL_ADMIN_LVL1 && st_reg.lun0 |-> st_reg.list_len == UNIT_LIST_LEN)
      else $error("code 11h from unit zero must list the unit");

   chk_sel11_zero: assert property (@(posedge clock_in) disable iff (rst_in)
      st_reg.sel_code == SEL_ADMIN_LVL1 && !st_reg.lun0 |-> st_reg.list_len == 32'h0)
      else $error("code 11h outside unit zero must give zero length");

   chk_sel12_len: assert property (@(posedge clock_in) disable iff (rst_in)
      st_reg.sel_code == SEL_CONGLOM |-> st_reg.list_len == (st_reg.admin ? 32'h8 : 32'h0))
      else $error("code 12h length wrong");

   // only an empty or a single-unit list can exist
   chk_list_size: assert property (@(posedge clock_in) disable iff (rst_in)
      st_reg.list_len == 32'h0 || st_reg.list_len == 32'h8)
      else $error("unit list length neither 0 nor 8");

   chk_list_word: assert property (@(posedge clock_in) disable iff (rst_in)
      setup && !pwrite_in && paddr_in == OFS_LIST0 && st_reg.list_len == 32'h8
         |=> prdata_out == 32'h0800_0000)
      else $error("length field not msb first");

   chk_unit_zero: assert property (@(posedge clock_in) disable iff (rst_in)
      setup && !pwrite_in && paddr_in > OFS_LIST0 && paddr_in <= OFS_LIST3 |=> prdata_out == 32'h0)
      else $error("reserved or unit id bytes not zero");

   // ----------------------------------------------------------------
   // checks: query result
   // ----------------------------------------------------------------
   // a block that is not the query must never return data
   chk_not_query: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && !cdb_bus.is_query |=> st_reg.check && st_reg.retlen == 32'h0)
      else $error("foreign command block accepted");

   // options 000b never refuses a well-formed query
   chk_all_form: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && cdb_bus.is_query && cdb_bus.rsvd_ok && cdb_bus.options == OPT_ALL
         |=> !st_reg.check && st_reg.all_fmt)
      else $error("all-commands form refused");

   chk_trunc_len: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && !st_next.check |=> st_reg.retlen <= $past(cdb_bus.alloc))
      else $error("returned more than allocation length");

   // a long enough allocation gets the whole parameter data
   chk_full_len: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && !st_next.check && cdb_bus.alloc >= avail |=> st_reg.retlen == $past(avail))
      else $error("parameter data cut although allocation was enough");

   chk_one_cmd_sa: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && cdb_bus.options == OPT_OP && op_has_sa |=> st_reg.check)
      else $error("service-action opcode not refused");

   chk_timeout_len: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && cdb_bus.is_query && cdb_bus.rsvd_ok && cdb_bus.options == OPT_OP_SA_ANY
         && td_flag && cdb_bus.alloc > 32'h100 |=> st_reg.retlen == 32'h1c)
      else $error("timeouts descriptor missing");

   chk_no_timeout: assert property (@(posedge clock_in) disable iff (rst_in)
      cdb_bus.done && cdb_bus.is_query && cdb_bus.rsvd_ok && cdb_bus.options == OPT_OP_SA_ANY
         && !td_flag && cdb_bus.alloc > 32'h100 |=> st_reg.retlen == 32'h10)
      else $error("timeouts descriptor not omitted");
endmodule
